/* File: twi_pkg.sv */
// Constants, types and helpers of the two-wire slave receiver.
// Assumes a byte-wide register port and a synchronous system clock.
package twi_pkg;

	// Register offsets on the plain register port
	localparam logic [1:0] OFS_CTRL = 2'h0;
	localparam logic [1:0] OFS_STAT = 2'h1;
	localparam logic [1:0] OFS_DATA = 2'h2;
	localparam logic [1:0] OFS_ADDR = 2'h3;

	// Control register field positions
	localparam int BIT_FLAG = 7;
	localparam int BIT_EA   = 6;
	localparam int BIT_STA  = 5;
	localparam int BIT_STO  = 4;
	localparam int BIT_EN   = 2;
	// Address register: general call accept bit
	localparam int BIT_GCA  = 0;

	// Reset values
	localparam logic [7:0] ADDR_RST  = 8'h00;
	localparam logic [7:0] DATA_RST  = 8'hff;
	localparam logic [7:0] STAT_IDLE = 8'hf8;

	// Status codes, prescaler bits zero
	localparam logic [7:0] CODE_OWN_W    = 8'h60;
	localparam logic [7:0] CODE_ARB_OWN  = 8'h68;
	localparam logic [7:0] CODE_GC       = 8'h70;
	localparam logic [7:0] CODE_ARB_GC   = 8'h78;
	localparam logic [7:0] CODE_OWN_ACK  = 8'h80;
	localparam logic [7:0] CODE_OWN_NACK = 8'h88;
	localparam logic [7:0] CODE_GC_ACK   = 8'h90;
	localparam logic [7:0] CODE_GC_NACK  = 8'h98;
	localparam logic [7:0] CODE_STOP     = 8'ha0;
	localparam logic [7:0] PRESC_MASK    = 8'hf8;

	localparam logic [6:0] GC_ADDR       = 7'h00;
	localparam logic       DIR_WRITE     = 1'b0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
		logic busy;
	} bus_evt_t;

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_WAIT, S_DATA, S_DATA_ACK, S_IGNORE
	} rx_state_t;

	// Status after an address (data=0) or data byte (data=1)
	function automatic logic [7:0] status_code(input logic gc,
		input logic arb, input logic data, input logic ack);
		logic [7:0] c;
		c = 8'h00;
		if (!data)
			c = gc ? (arb ? CODE_ARB_GC : CODE_GC)
			       : (arb ? CODE_ARB_OWN : CODE_OWN_W);
		else
			c = gc ? (ack ? CODE_GC_ACK : CODE_GC_NACK)
			       : (ack ? CODE_OWN_ACK : CODE_OWN_NACK);
		return c;
	endfunction : status_code

endpackage : twi_pkg

/* File: bit_sync.sv */
// Two-flop synchroniser for the clock and data pins of the bus.
// Assumes the pins are asynchronous to the system clock.
`timescale 1ns/100ps
module bit_sync
	import twi_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       SYS_RST,
	input  wire logic [1:0] D,
	output logic      [1:0] Q
);
	logic [1:0] meta_r;

	// Idle bus level is high on both lines
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			meta_r <= 2'h3;
			Q      <= 2'h3;
		end else begin
			meta_r <= D;
			Q      <= meta_r;
		end
	end
endmodule : bit_sync

/* File: bus_monitor.sv */
// Start, stop and clock edge detection on the synchronised bus lines.
// Assumes inputs already passed the synchroniser.
`timescale 1ns/100ps
module bus_monitor
	import twi_pkg::*;
(
	input  wire logic SYS_CLK,
	input  wire logic SYS_RST,
	input  wire logic SCL,
	input  wire logic SDA,
	output bus_evt_t  EVT
);
	logic scl_r;
	logic sda_r;
	logic busy_r;
	wire  start_w = scl_r && SCL && sda_r && !SDA;
	wire  stop_w  = scl_r && SCL && !sda_r && SDA;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			scl_r  <= 1'b1;
			sda_r  <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			scl_r  <= SCL;
			sda_r  <= SDA;
			busy_r <= start_w ? 1'b1 : (stop_w ? 1'b0 : busy_r);
		end
	end

	assign EVT.start    = start_w;
	assign EVT.stop     = stop_w;
	assign EVT.scl_rise = !scl_r && SCL;
	assign EVT.scl_fall = scl_r && !SCL;
	assign EVT.sda      = SDA;
	assign EVT.busy     = busy_r;
endmodule : bus_monitor

/* File: two_wire_slave_receiver.sv */
// Slave receiver of a byte-oriented two-wire serial interface.
// Assumes open-drain pins resolved outside and a same-clock register master.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
//
// Summary of operation
// - Receives data bytes from a master; status reads with prescaler bits zero.
// - Own seven-bit address comes from address register bits 7:1.
// - Address register bit 0 enables answering the general call address 0x00.
// - Address with direction bit 0 selects reception; read direction ignored.
// - Own address plus write acknowledged sets the flag with status 0x60.
// - Addressed after lost arbitration reports 0x68 own, 0x78 general call.
// - General call acknowledged sets the flag with status 0x70.
// - Acknowledge enable cleared gives a not-acknowledge after next byte.
// - Acknowledge enable zero ignores own address; recognition resumes when set.
// - In deep sleep the address still matches and the system is woken.
// - After wake-up clock line stays low until the flag is cleared.
// - In deep sleep the data register is not updated from the bus.
// - After address states, acknowledge enable decides the next byte's answer.
// - Status 0x80: byte acknowledged after own address selection.
// - Status 0x88: byte not acknowledged; then not-addressed slave state.
// - Start request answering status 0x88 or 0x98 issues START when bus free.
// - Status 0x90: byte acknowledged after general call selection.
// - Status 0x98: byte not acknowledged after general call; leave addressed.
// - Stop or repeated start while addressed reports 0xA0 and leaves.
module two_wire_slave_receiver
	import twi_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       SYS_RST,
	input  wire logic [1:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	input  wire logic       SCL_I,
	output logic            SCL_O,
	output logic            SCL_OE_N,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_N,
	input  wire logic       DEEP_SLEEP,
	input  wire logic       ARB_LOST,
	output logic            WAKE_REQ,
	output logic            START_ISSUE
);
	logic [1:0] pins_s;
	bus_evt_t   evt;
	rx_state_t  state_r;
	rx_state_t  state_nxt;
	logic       ea_r, sta_r, sto_r, en_r, flag_r;
	logic [7:0] addr_reg_r;
	logic [7:0] data_r;
	logic [7:0] stat_r;
	logic [7:0] shreg_r;
	logic [3:0] cnt_r;
	logic       gc_sel_r, ack_r, sda_low_r, done_r;
	logic       arb_r, wake_r, start_pend_r, start_issue_r;
	logic [7:0] rdata_r;
	logic [7:0] stat_nxt;
	bit_sync u_sync (
		.SYS_CLK (SYS_CLK),
		.SYS_RST (SYS_RST),
		.D       ({SCL_I, SDA_I}),
		.Q       (pins_s)
	);

	bus_monitor u_mon (
		.SYS_CLK (SYS_CLK),
		.SYS_RST (SYS_RST),
		.SCL     (pins_s[1]),
		.SDA     (pins_s[0]),
		.EVT     (evt)
	);

	wire wr_ctrl   = REG_WR && (REG_ADDR == OFS_CTRL);
	wire wr_data   = REG_WR && (REG_ADDR == OFS_DATA);
	wire wr_addr   = REG_WR && (REG_ADDR == OFS_ADDR);
	wire flag_clr  = wr_ctrl && REG_WDATA[BIT_FLAG];
	wire own_hit   = shreg_r[7:1] == addr_reg_r[7:1];
	wire gc_hit    = (shreg_r[7:1] == GC_ADDR) && addr_reg_r[BIT_GCA];
	wire dir_wr    = shreg_r[0] == DIR_WRITE;
	// Acknowledge enable gates recognition; deep sleep keeps matching
	wire addr_ok   = en_r && ea_r && dir_wr && (own_hit || gc_hit);
	wire byte_done = evt.scl_fall && (cnt_r == BITS_PER_BYTE);
	wire addr_end  = (state_r == S_ADDR_ACK) && evt.scl_fall;
	wire data_end  = (state_r == S_DATA_ACK) && evt.scl_fall;
	wire data_byte = (state_r == S_DATA) && byte_done;
	wire addr_byte = (state_r == S_ADDR) && byte_done;
	wire cond_rx   = (state_r == S_DATA) && (evt.stop || evt.start);
	wire flag_set  = addr_end || data_end || cond_rx;
	wire leave_now = (state_r == S_WAIT) && !flag_r;
	wire bit_phase = (state_r == S_ADDR) || (state_r == S_DATA);
	wire stretch   = state_r == S_WAIT;
	wire issue_now = start_pend_r && !evt.busy;

	// Status chosen by selection kind and acknowledge answer
	always_comb begin
		stat_nxt = stat_r;
		if (addr_end)
			stat_nxt = status_code(gc_sel_r, arb_r, 1'b0, 1'b1);
		else if (data_end)
			stat_nxt = status_code(gc_sel_r, 1'b0, 1'b1, ack_r);
		else if (cond_rx)
			stat_nxt = CODE_STOP;
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
		S_IDLE, S_IGNORE:
			if (evt.start)
				state_nxt = S_ADDR;
		S_ADDR:
			if (evt.stop)
				state_nxt = S_IDLE;
			else if (evt.start)
				state_nxt = S_ADDR;
			else if (byte_done)
				state_nxt = addr_ok ? S_ADDR_ACK : S_IGNORE;
		S_ADDR_ACK:
			if (evt.scl_fall)
				state_nxt = S_WAIT;
		S_WAIT:
			if (!flag_r)
				state_nxt = done_r ? S_IDLE : S_DATA;
		S_DATA:
			if (evt.stop)
				state_nxt = S_IDLE;
			else if (evt.start)
				state_nxt = S_ADDR;
			else if (byte_done)
				state_nxt = S_DATA_ACK;
		S_DATA_ACK:
			if (evt.scl_fall)
				state_nxt = S_WAIT;
		default:
			state_nxt = S_IDLE;
		endcase
		if (!en_r)
			state_nxt = S_IDLE;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			state_r <= S_IDLE;
		else
			state_r <= state_nxt;
	end

	// Control bits; software must set enable and acknowledge enable first
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ea_r  <= 1'b0;
			sta_r <= 1'b0;
			sto_r <= 1'b0;
			en_r  <= 1'b0;
		end else if (wr_ctrl) begin
			ea_r  <= REG_WDATA[BIT_EA];
			sta_r <= REG_WDATA[BIT_STA];
			sto_r <= REG_WDATA[BIT_STO];
			en_r  <= REG_WDATA[BIT_EN];
		end
	end

	// A new event beats a clear in the same cycle
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			flag_r <= 1'b0;
		else if (flag_set)
			flag_r <= 1'b1;
		else if (flag_clr)
			flag_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			addr_reg_r <= ADDR_RST;
			stat_r     <= STAT_IDLE;
		end else begin
			if (wr_addr)
				addr_reg_r <= REG_WDATA;
			stat_r <= stat_nxt;
		end
	end

	// Bus byte is lost in deep sleep; otherwise it beats a software write
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			data_r <= DATA_RST;
		else if (data_byte && !DEEP_SLEEP)
			data_r <= shreg_r;
		else if (wr_data)
			data_r <= REG_WDATA;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			shreg_r <= 8'h00;
			cnt_r   <= 4'h0;
		end else if (evt.start || leave_now) begin
			cnt_r   <= 4'h0;
		end else if (bit_phase && evt.scl_rise) begin
			shreg_r <= {shreg_r[6:0], evt.sda};
			cnt_r   <= cnt_r + 4'h1;
		end else if (byte_done) begin
			cnt_r   <= 4'h0;
		end
	end

	// Acknowledge drive: own address, general call, or data with enable
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sda_low_r <= 1'b0;
			ack_r     <= 1'b0;
			gc_sel_r  <= 1'b0;
			done_r    <= 1'b0;
		end else begin
			if (addr_byte && addr_ok) begin
				sda_low_r <= 1'b1;
				gc_sel_r  <= gc_hit && !own_hit;
				done_r    <= 1'b0;
			end else if (data_byte) begin
				sda_low_r <= ea_r;
				ack_r     <= ea_r;
				done_r    <= !ea_r;
			end else if (addr_end || data_end || !en_r) begin
				sda_low_r <= 1'b0;
			end
			if (cond_rx)
				done_r <= 1'b1;
		end
	end

	// Lost arbitration is a same-clock pulse from the master logic
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			arb_r <= 1'b0;
		else if (ARB_LOST)
			arb_r <= 1'b1;
		else if (addr_end || state_r == S_IGNORE)
			arb_r <= 1'b0;
	end

	// Long wake-up keeps the clock line low and blocks the bus
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			wake_r <= 1'b0;
		else if (addr_end && DEEP_SLEEP)
			wake_r <= 1'b1;
		else if (flag_clr)
			wake_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			start_pend_r  <= 1'b0;
			start_issue_r <= 1'b0;
		end else begin
			start_issue_r <= issue_now;
			if (flag_clr && stretch && done_r && REG_WDATA[BIT_STA])
				start_pend_r <= 1'b1;
			else if (issue_now)
				start_pend_r <= 1'b0;
		end
	end

	wire [7:0] ctrl_rd = {flag_r, ea_r, sta_r, sto_r, 1'b0, en_r, 2'h0};
	wire [7:0] rd_mux  = (REG_ADDR == OFS_CTRL) ? ctrl_rd :
	                     (REG_ADDR == OFS_STAT) ? (stat_r & PRESC_MASK) :
	                     (REG_ADDR == OFS_DATA) ? data_r : addr_reg_r;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			rdata_r <= 8'h00;
		else
			rdata_r <= REG_RD ? rd_mux : 8'h00;
	end

	assign REG_RDATA   = rdata_r;
	assign SCL_O       = 1'b0;
	assign SDA_O       = 1'b0;
	assign SCL_OE_N    = !stretch;
	assign SDA_OE_N    = !sda_low_r;
	assign WAKE_REQ    = wake_r;
	assign START_ISSUE = start_issue_r;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	sequence own_addr_taken;
		addr_end && !gc_sel_r && !arb_r;
	endsequence
	sequence gc_addr_taken;
		addr_end && gc_sel_r && !arb_r;
	endsequence
	sequence data_nacked;
		data_byte && !ea_r;
	endsequence
	AST_OWN_CODE: assert property (own_addr_taken |=>
		flag_r && stat_r == CODE_OWN_W && !SCL_OE_N)
		else $error("own address status wrong");
	AST_GC_CODE: assert property (gc_addr_taken |=>
		flag_r && stat_r == CODE_GC)
		else $error("general call status wrong");
	AST_ARB_CODE: assert property (addr_end && arb_r |=>
		stat_r == (gc_sel_r ? CODE_ARB_GC : CODE_ARB_OWN))
		else $error("lost arbitration status wrong");
	AST_NACK_BYTE: assert property (data_nacked |=>
		SDA_OE_N [*2])
		else $error("data line driven without enable");
	AST_ADDR_OFF: assert property (addr_byte && !ea_r |=>
		state_r == S_IGNORE && SDA_OE_N)
		else $error("address answered with enable off");
	AST_GC_OFF: assert property (addr_byte && shreg_r == 8'h00 &&
		!addr_reg_r[BIT_GCA] && addr_reg_r[7:1] != GC_ADDR |=>
		state_r != S_ADDR_ACK)
		else $error("general call accepted while disabled");
	AST_HOLD_LOW: assert property ($fell(SCL_OE_N) |-> flag_r)
		else $error("clock held without flag");
	AST_RELEASE: assert property (stretch && flag_clr && !flag_set |=>
		!flag_r ##1 SCL_OE_N)
		else $error("clock not released after clear");
	AST_OWN_DATA: assert property (data_end && ack_r && !gc_sel_r |=>
		stat_r == CODE_OWN_ACK ##1 state_r == S_WAIT)
		else $error("own data status wrong");
	AST_LEAVE: assert property (leave_now && done_r |=>
		state_r == S_IDLE)
		else $error("addressed mode not left");
	AST_STOP_CODE: assert property ((state_r == S_DATA) && evt.stop |=>
		stat_r == CODE_STOP && flag_r && state_r == S_IDLE)
		else $error("stop status wrong");
	AST_SLEEP_DATA: assert property (data_byte && DEEP_SLEEP && !wr_data |=>
		$stable(data_r))
		else $error("data updated in deep sleep");
	AST_WAKE: assert property (addr_end && DEEP_SLEEP |=> WAKE_REQ)
		else $error("no wake request");
	AST_START: assert property (issue_now |=> START_ISSUE && !start_pend_r)
		else $error("start not issued");
endmodule : two_wire_slave_receiver

/* File: twi_bus_master.sv */
// Behavioural two-wire bus master transmitter for the slave receiver bench.
// Assumes the bench resolves both open-drain lines with a pull-up.
`timescale 1ns/100ps
module twi_bus_master
	import twi_pkg::*;
(
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_o,
	output logic      sda_o
);
	// Quarter of the 64 ns link period
	localparam time Q = 16ns;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Waits on the clock line so a stretching slave holds us off
	task automatic bit_cycle(input logic b, output logic v);
		sda_o = b;
		#Q;
		scl_o = 1'b1;
		wait (scl === 1'b1);
		#Q;
		v = sda;
		#Q;
		scl_o = 1'b0;
		#Q;
	endtask : bit_cycle

	task automatic start_cond();
		sda_o = 1'b1;
		#Q;
		scl_o = 1'b1;
		wait (scl === 1'b1);
		#Q;
		sda_o = 1'b0;
		#Q;
		scl_o = 1'b0;
		#Q;
	endtask : start_cond

	task automatic stop_cond();
		sda_o = 1'b0;
		#Q;
		scl_o = 1'b1;
		wait (scl === 1'b1);
		#Q;
		sda_o = 1'b1;
		#(2 * Q);
	endtask : stop_cond

	// Data line released in the ninth slot so the slave can answer
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], v);
		end
		bit_cycle(1'b1, v);
		ack = ~v;
	endtask : put_byte
endmodule : twi_bus_master

/* File: tb_two_wire_slave_receiver.sv */
// Self-checking bench of the two-wire slave receiver.
// Assumes the bus master model and the register port of the design.
`timescale 1ns/100ps
module tb_two_wire_slave_receiver
	import twi_pkg::*;
;
	logic       clk;
	logic       rst;
	logic [1:0] ra;
	logic [7:0] wd;
	logic       wr_s;
	logic       rd_s;
	logic [7:0] rdat;
	logic       m_scl;
	logic       m_sda;
	logic       scl_od;
	logic       scl_oe_n;
	logic       sda_od;
	logic       sda_oe_n;
	logic       deep;
	logic       arb;
	logic       wake;
	logic       st_iss;
	logic       scl;
	logic       sda;
	int         error_cnt;
	int         total_checks;
	int         cyc;
	int         sic;
	logic [7:0] last_st;

	assign scl = scl_oe_n ? m_scl : (m_scl & scl_od);
	assign sda = sda_oe_n ? m_sda : (m_sda & sda_od);

	two_wire_slave_receiver i_dut (
		.SYS_CLK    (clk),
		.SYS_RST    (rst),
		.REG_ADDR   (ra),
		.REG_WDATA  (wd),
		.REG_WR     (wr_s),
		.REG_RD     (rd_s),
		.REG_RDATA  (rdat),
		.SCL_I      (scl),
		.SCL_O      (scl_od),
		.SCL_OE_N   (scl_oe_n),
		.SDA_I      (sda),
		.SDA_O      (sda_od),
		.SDA_OE_N   (sda_oe_n),
		.DEEP_SLEEP (deep),
		.ARB_LOST   (arb),
		.WAKE_REQ   (wake),
		.START_ISSUE(st_iss)
	);

	twi_bus_master i_mst (
		.scl  (scl),
		.sda  (sda),
		.scl_o(m_scl),
		.sda_o(m_sda)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	// Ceiling well above the roughly 2000 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (st_iss === 1'b1)
			sic++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("[FAIL] %0t run did not finish", $time);
			conclude();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		ra   <= a;
		wd   <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		ra   <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdat, exp);
	endtask : rd

	// Status keeps its last code while no new event is raised
	task automatic st_chk(input logic [7:0] st);
		if (st != STAT_IDLE)
			last_st = st;
		rd(OFS_STAT, last_st);
	endtask : st_chk

	// Stretch expected exactly when a status other than idle is pending
	task automatic bt(input logic [7:0] b, input logic ea,
		input logic [7:0] st);
		logic a;
		i_mst.put_byte(b, a);
		repeat (8) @(posedge clk);
		chk({7'h0, a}, {7'h0, ea});
		chk({7'h0, scl_oe_n}, {7'h0, st == STAT_IDLE});
		st_chk(st);
	endtask : bt

	task automatic ev(input logic p, input logic [7:0] st);
		if (p)
			i_mst.stop_cond();
		else
			i_mst.start_cond();
		repeat (8) @(posedge clk);
		chk({7'h0, scl_oe_n}, 8'h01);
		st_chk(st);
	endtask : ev

	task automatic arb_pulse();
		@(posedge clk);
		arb <= 1'b1;
		@(posedge clk);
		arb <= 1'b0;
	endtask : arb_pulse

	initial begin
		rst = 1'b1;
		ra = 2'h0;
		wd = 8'h00;
		wr_s = 1'b0;
		rd_s = 1'b0;
		deep = 1'b0;
		arb = 1'b0;
		last_st = STAT_IDLE;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CTRL, 8'h00);
		rd(OFS_STAT, STAT_IDLE);
		rd(OFS_DATA, DATA_RST);
		rd(OFS_ADDR, ADDR_RST);
		wr(OFS_CTRL, 8'h4f);
		rd(OFS_CTRL, 8'h44);
		wr(OFS_ADDR, 8'ha4);
		rd(OFS_ADDR, 8'ha4);
		wr(OFS_DATA, 8'h96);
		rd(OFS_DATA, 8'h96);
		i_mst.start_cond();
		bt(8'ha5, 1'b0, STAT_IDLE);
		i_mst.start_cond();
		bt(8'ha6, 1'b0, STAT_IDLE);
		i_mst.start_cond();
		bt(8'ha4, 1'b1, CODE_OWN_W);
		wr(OFS_CTRL, 8'hc4);
		bt(8'h3c, 1'b1, CODE_OWN_ACK);
		rd(OFS_DATA, 8'h3c);
		wr(OFS_CTRL, 8'h84);
		bt(8'h5a, 1'b0, CODE_OWN_NACK);
		rd(OFS_DATA, 8'h5a);
		wr(OFS_CTRL, 8'hc4);
		bt(8'h11, 1'b0, STAT_IDLE);
		ev(1'b1, STAT_IDLE);
		i_mst.start_cond();
		bt({GC_ADDR, DIR_WRITE}, 1'b0, STAT_IDLE);
		ev(1'b1, STAT_IDLE);
		wr(OFS_ADDR, 8'ha5);
		i_mst.start_cond();
		bt({GC_ADDR, DIR_WRITE}, 1'b1, CODE_GC);
		wr(OFS_CTRL, 8'hc4);
		bt(8'h77, 1'b1, CODE_GC_ACK);
		rd(OFS_DATA, 8'h77);
		wr(OFS_CTRL, 8'h84);
		bt(8'h78, 1'b0, CODE_GC_NACK);
		wr(OFS_CTRL, 8'he4);
		chk(sic[7:0], 8'h00);
		ev(1'b1, STAT_IDLE);
		chk(sic[7:0], 8'h01);
		wr(OFS_CTRL, 8'h04);
		i_mst.start_cond();
		bt(8'ha4, 1'b0, STAT_IDLE);
		ev(1'b1, STAT_IDLE);
		wr(OFS_CTRL, 8'h44);
		i_mst.start_cond();
		bt(8'ha4, 1'b1, CODE_OWN_W);
		wr(OFS_CTRL, 8'hc4);
		bt(8'h01, 1'b1, CODE_OWN_ACK);
		wr(OFS_CTRL, 8'hc4);
		ev(1'b0, CODE_STOP);
		wr(OFS_CTRL, 8'hc4);
		bt(8'ha4, 1'b1, CODE_OWN_W);
		wr(OFS_CTRL, 8'hc4);
		ev(1'b1, CODE_STOP);
		wr(OFS_CTRL, 8'hc4);
		arb_pulse();
		i_mst.start_cond();
		bt(8'ha4, 1'b1, CODE_ARB_OWN);
		wr(OFS_CTRL, 8'hc4);
		ev(1'b1, CODE_STOP);
		wr(OFS_CTRL, 8'hc4);
		arb_pulse();
		i_mst.start_cond();
		bt({GC_ADDR, DIR_WRITE}, 1'b1, CODE_ARB_GC);
		wr(OFS_CTRL, 8'hc4);
		ev(1'b1, CODE_STOP);
		wr(OFS_CTRL, 8'hc4);
		deep <= 1'b1;
		i_mst.start_cond();
		bt(8'ha4, 1'b1, CODE_OWN_W);
		chk({7'h0, wake}, 8'h01);
		repeat (20) @(posedge clk);
		chk({7'h0, scl_oe_n}, 8'h00);
		wr(OFS_CTRL, 8'hc4);
		repeat (4) @(posedge clk);
		chk({7'h0, wake}, 8'h00);
		chk({7'h0, scl_oe_n}, 8'h01);
		// Byte taken in deep sleep leaves the data register as it was
		bt(8'h5c, 1'b1, CODE_OWN_ACK);
		rd(OFS_DATA, 8'h01);
		deep <= 1'b0;
		wr(OFS_CTRL, 8'hc4);
		ev(1'b1, CODE_STOP);
		wr(OFS_CTRL, 8'hc4);
		conclude();
	end
endmodule : tb_two_wire_slave_receiver
